// ==== rtl/lciu_irq.sv ====
// Per-channel line interface interrupt enables, event flags and request logic.
`timescale 1ns/1ps
module lciu_irq
  import lciu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [CHANNELS-1:0] i_line_viol,
  input wire logic [CHANNELS-1:0] i_loop_code_det,
  input wire logic [CHANNELS-1:0] i_signal_loss,
  input wire logic [CHANNELS-1:0] i_test_pattern_det,
  input wire logic [CHANNELS-1:0] i_liu_single_rail,
  input wire logic [CHANNELS-1:0] i_framer_single_rail,
  output logic [DATA_W-1:0] o_rdata,
  output logic [CHANNELS-1:0] o_chan_irq,
  output logic o_irq
);

  logic [7:0] en_r [CHANNELS];
  logic [7:0] en_nxt [CHANNELS];
  logic [7:0] prev_r [CHANNELS];
  logic [7:0] prev_nxt [CHANNELS];
  logic [7:0] evt_r [CHANNELS];
  logic [7:0] evt_nxt [CHANNELS];
  logic [7:0] cond_w [CHANNELS];
  logic [7:0] change_w [CHANNELS];
  logic [7:0] clear_w [CHANNELS];
  logic [CHANNELS-1:0] gate_w;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // True when the address selects the given register of the given channel.
  function automatic logic reg_sel(input logic [ADDR_W-1:0] a, input int c,
                                   input logic [3:0] ofs);
    return (a[15:8] == PAGE) && (a[7:4] == 4'(c)) && (a[3:0] == ofs);
  endfunction : reg_sel

  // Condition levels, transitions and software clears for every channel.
  always_comb
  begin
    for (int c = 0; c < CHANNELS; c++)
    begin
      // Without single rail on both sides the detectors are meaningless.
      gate_w[c] = i_liu_single_rail[c] & i_framer_single_rail[c];
      cond_w[c] = lciu_place(i_line_viol[c], i_loop_code_det[c],
                             i_signal_loss[c], i_test_pattern_det[c]);
      // Both edges count, so declare and clear each raise an event.
      change_w[c] = (cond_w[c] ^ prev_r[c]) & {8{gate_w[c]}} & FIELD_MASK;
      clear_w[c] = (i_wr && reg_sel(i_addr, c, OFS_EVENT)) ? i_wdata : 8'h00;
    end
  end

  // Next register values; everything holds while the clock enable is low.
  always_comb
  begin
    for (int c = 0; c < CHANNELS; c++)
    begin
      en_nxt[c] = en_r[c];
      // History tracks even outside single rail, so re-entry raises no stale event.
      prev_nxt[c] = prev_r[c];
      evt_nxt[c] = evt_r[c];
      if (i_ce)
      begin
        if (i_wr && reg_sel(i_addr, c, OFS_ENABLE))
        begin
          en_nxt[c] = i_wdata & FIELD_MASK;
        end
        prev_nxt[c] = cond_w[c];
        // A set in the same cycle as its clear wins, so no event is lost.
        evt_nxt[c] = (evt_r[c] & ~clear_w[c]) | change_w[c];
      end
    end
  end

  // Read data stand for the cycle after the read strobe, and hold while the clock enable is low.
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (i_ce)
    begin
      rdata_nxt = 8'h00;
      for (int c = 0; c < CHANNELS; c++)
      begin
        if (i_rd && reg_sel(i_addr, c, OFS_ENABLE))
        begin
          rdata_nxt = en_r[c];
        end
        if (i_rd && reg_sel(i_addr, c, OFS_COND))
        begin
          rdata_nxt = cond_w[c];
        end
        if (i_rd && reg_sel(i_addr, c, OFS_EVENT))
        begin
          rdata_nxt = evt_r[c];
        end
      end
    end
  end

  // State registers.
  // Levels are sampled only on enabled edges, so a pulse that starts and ends while
  // the clock enable is low is never seen; that is the price of a true freeze.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      for (int c = 0; c < CHANNELS; c++)
      begin
        en_r[c] <= ENABLE_RESET;
        prev_r[c] <= 8'h00;
        evt_r[c] <= EVENT_RESET;
      end
      rdata_r <= 8'h00;
    end
    else
    begin
      for (int c = 0; c < CHANNELS; c++)
      begin
        en_r[c] <= en_nxt[c];
        prev_r[c] <= prev_nxt[c];
        evt_r[c] <= evt_nxt[c];
      end
      rdata_r <= rdata_nxt;
    end
  end

  // Requests are level outputs, gated by the enables held as the mask.
  // Events are kept whatever the enable, so enabling later reports an old event;
  // software should clear the event register before it raises an enable.
  always_comb
  begin
    for (int c = 0; c < CHANNELS; c++)
    begin
      o_chan_irq[c] = |(evt_r[c] & en_r[c] & FIELD_MASK);
    end
  end
  assign o_irq = |o_chan_irq;
  assign o_rdata = rdata_r;

  // Checks per channel.
  // Transitions are judged against the stored history, not the sampled past,
  // because a low clock enable may skip edges in between.
  for (genvar g = 0; g < CHANNELS; g++)
  begin : g_chk
    // A write to the enable in the same cycle may drop the request, so it is excluded.
    a_line_viol_event: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_ce && change_w[g][BIT_LINE_VIOL] && en_r[g][BIT_LINE_VIOL]
      && !(i_wr && reg_sel(i_addr, g, OFS_ENABLE)) |=> o_chan_irq[g])
      else $error("Line violation event did not raise the request.");
    a_line_viol_masked: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ((evt_r[g] & en_r[g]) == 8'h00) |-> !o_chan_irq[g])
      else $error("Request raised with no enabled event.");
    a_loop_code_fall: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_ce && gate_w[g] && prev_r[g][BIT_LOOP_CODE] && !i_loop_code_det[g]
      |=> evt_r[g][BIT_LOOP_CODE])
      else $error("Loop code loss did not set its event.");
    a_bit_two_inert: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !en_r[g][BIT_UNUSED] && !evt_r[g][BIT_UNUSED])
      else $error("Unused bit holds state.");
    a_signal_loss_both: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_ce && gate_w[g] && (i_signal_loss[g] != prev_r[g][BIT_SIGNAL_LOSS])
      |=> evt_r[g][BIT_SIGNAL_LOSS])
      else $error("Signal loss transition missed.");
    a_test_pattern_rise: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_ce && gate_w[g] && !prev_r[g][BIT_TEST_PATTERN] && i_test_pattern_det[g]
      |=> evt_r[g][BIT_TEST_PATTERN])
      else $error("Test pattern detection missed.");
    a_enable_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_ce && i_wr && reg_sel(i_addr, g, OFS_ENABLE)
      |=> en_r[g] == ($past(i_wdata) & FIELD_MASK))
      else $error("Enable write not stored.");
    a_enable_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_ce && i_rd && reg_sel(i_addr, g, OFS_ENABLE) |=> o_rdata == $past(en_r[g]))
      else $error("Enable read back wrong.");
    // The condition register shows the live levels at their field positions.
    a_cond_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_ce && i_rd && reg_sel(i_addr, g, OFS_COND) |=> o_rdata == $past(cond_w[g]))
      else $error("Condition read back wrong.");
    a_rail_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_ce && !gate_w[g] && clear_w[g] == 8'h00 |=> evt_r[g] == $past(evt_r[g]))
      else $error("Event set outside single rail mode.");
    a_set_wins: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_ce && (change_w[g] & clear_w[g]) != 8'h00
      |=> (evt_r[g] & $past(change_w[g])) == $past(change_w[g]))
      else $error("Clear beat a simultaneous event.");
    a_event_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_ce && (clear_w[g] & ~change_w[g]) != 8'h00
      |=> (evt_r[g] & $past(clear_w[g] & ~change_w[g])) == 8'h00)
      else $error("Written one did not clear its event.");
    // Low clock enable must hold the enable and event registers of the channel.
    a_ce_freeze: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !i_ce |=> en_r[g] == $past(en_r[g]) && evt_r[g] == $past(evt_r[g]))
      else $error("State moved while the clock enable was low.");
    c_event_cleared: cover property (@(posedge i_clk) disable iff (!i_nrst)
      o_chan_irq[g] ##[1:20] !o_chan_irq[g]);
  end

  a_irq_combine: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_irq == (o_chan_irq != '0))
    else $error("Combined request disagrees with channels.");
  // Read data fall back to zero one cycle after any enabled cycle without a read.
  a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_ce && !i_rd |=> o_rdata == 8'h00)
    else $error("Read data stood longer than one cycle.");
  // A frozen cycle hides a level change until the enable returns.
  c_frozen_change: cover property (@(posedge i_clk) disable iff (!i_nrst)
    !i_ce && change_w[3] != 8'h00);
  c_rail_blocked: cover property (@(posedge i_clk) disable iff (!i_nrst)
    !gate_w[3] && (cond_w[3] ^ prev_r[3]) != 8'h00);
  c_two_channels: cover property (@(posedge i_clk) disable iff (!i_nrst)
    o_chan_irq[0] && o_chan_irq[3]);
  c_enable_then_irq: cover property (@(posedge i_clk) disable iff (!i_nrst)
    (i_wr && i_addr == {PAGE, 4'h1, OFS_ENABLE}) ##[1:10] o_chan_irq[1]);
endmodule : lciu_irq

// ==== rtl/lciu_pkg.sv ====
// Constants shared by the line channel interrupt enable block.
package lciu_pkg;
  localparam int CHANNELS = 4;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // Channel n registers sit at PAGE, n, offset.
  localparam logic [7:0] PAGE = 8'h0F;
  localparam logic [3:0] OFS_ENABLE = 4'h4;
  localparam logic [3:0] OFS_COND = 4'h5;
  localparam logic [3:0] OFS_EVENT = 4'h6;
  // Field positions shared by the enable, condition and event registers.
  localparam int BIT_LINE_VIOL = 4;
  localparam int BIT_LOOP_CODE = 3;
  localparam int BIT_UNUSED = 2;
  localparam int BIT_SIGNAL_LOSS = 1;
  localparam int BIT_TEST_PATTERN = 0;
  localparam logic [7:0] FIELD_MASK = 8'h1B;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] EVENT_RESET = 8'h00;

  // Places the four source levels at their field positions.
  function automatic logic [7:0] lciu_place(input logic lv, input logic lc,
                                            input logic sl, input logic tp);
    logic [7:0] v;
    v = 8'h00;
    v[BIT_LINE_VIOL] = lv;
    v[BIT_LOOP_CODE] = lc;
    v[BIT_SIGNAL_LOSS] = sl;
    v[BIT_TEST_PATTERN] = tp;
    return v;
  endfunction : lciu_place
endpackage : lciu_pkg

// ==== verification/test_liu_channel_irq_enable.sv ====
// Self-checking testbench for the per-channel line interrupt enable block.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module test_liu_channel_irq_enable;
  import lciu_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_ce = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic [DATA_W-1:0] rd_v;
  logic [3:0] src [0:4] = '{default: '0};
  logic [3:0] liu_sr = 4'hF;
  logic [3:0] frm_sr = 4'hF;
  logic [DATA_W-1:0] o_rdata;
  logic [CHANNELS-1:0] o_chan_irq;
  logic o_irq;
  int mismatches = 0;
  int n_checks = 0;
  // Table rows: channel, field bit, and whether the request should follow.
  int row_ch [8] = '{0, 1, 2, 3, 1, 2, 3, 0};
  int row_b [8] = '{4, 3, 1, 0, 4, 3, 1, 0};
  logic row_irq [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

  lciu_irq u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_line_viol(src[4]),
    .i_loop_code_det(src[3]), .i_signal_loss(src[1]), .i_test_pattern_det(src[0]),
    .i_liu_single_rail(liu_sr), .i_framer_single_rail(frm_sr), .o_rdata(o_rdata),
    .o_chan_irq(o_chan_irq), .o_irq(o_irq));

  // Free-running 100 MHz clock.
  always #5 i_clk = ~i_clk;

  function automatic logic [15:0] ra(input int ch, input logic [3:0] ofs);
    return {PAGE, 4'(ch), ofs};
  endfunction : ra

  // Bus cycles hold every signal for one full cycle so the strobe is sampled once.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd_v = o_rdata;
  endtask : rd

  // Toggles one source level and lets two edges pass so the event lands.
  task automatic flip(input int b, input int ch);
    @(posedge i_clk);
    src[b][ch] <= ~src[b][ch];
    repeat (2) @(posedge i_clk);
    #1;
  endtask : flip

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // Main sequence: reset, table rows, then the awkward cases.
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(ra(2, OFS_ENABLE));
    `CHK(rd_v, ENABLE_RESET)
    `CHK(o_irq, 1'b0)
    // Read data stand for one cycle only.
    @(posedge i_clk);
    #1;
    `CHK(o_rdata, 8'h00)
    for (int r = 0; r < 8; r++)
    begin
      wr(ra(row_ch[r], OFS_ENABLE), row_irq[r] ? 8'(1 << row_b[r]) : 8'h00);
      // Both the rising and the falling change must give an event.
      for (int k = 0; k < 2; k++)
      begin
        flip(row_b[r], row_ch[r]);
        `CHK(o_chan_irq[row_ch[r]], row_irq[r])
        `CHK(o_irq, row_irq[r])
        rd(ra(row_ch[r], OFS_EVENT));
        `CHK(rd_v, 8'(1 << row_b[r]))
        wr(ra(row_ch[r], OFS_EVENT), rd_v);
        `CHK(o_chan_irq, 4'h0)
      end
    end
    // Bit two must not stick even when software writes ones everywhere.
    wr(ra(3, OFS_ENABLE), 8'hFF);
    rd(ra(3, OFS_ENABLE));
    `CHK(rd_v, FIELD_MASK)
    // Without single rail on the line side no event is recorded.
    @(posedge i_clk);
    liu_sr <= 4'h7;
    flip(4, 3);
    `CHK(o_chan_irq[3], 1'b0)
    @(posedge i_clk);
    liu_sr <= 4'hF;
    // Condition register shows the live level left high by the blocked toggle.
    rd(ra(3, OFS_COND));
    `CHK(rd_v, 8'(1 << BIT_LINE_VIOL))
    // A low clock enable freezes history, so the change shows once it returns.
    @(posedge i_clk);
    i_ce <= 1'b0;
    flip(1, 3);
    `CHK(o_chan_irq[3], 1'b0)
    @(posedge i_clk);
    i_ce <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    `CHK(o_chan_irq[3], 1'b1)
    rd(ra(3, OFS_EVENT));
    `CHK(rd_v, 8'(1 << BIT_SIGNAL_LOSS))
    wr(ra(3, OFS_EVENT), rd_v);
    `CHK(o_irq, 1'b0)
    rd(16'h0E34);
    `CHK(rd_v, 8'h00)
    // A second reset in mid-run must bring the enables back to zero.
    @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_clk);
    `CHK(o_irq, 1'b0)
    i_nrst <= 1'b1;
    rd(ra(3, OFS_ENABLE));
    `CHK(rd_v, ENABLE_RESET)
    close_out;
  end

  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial
  begin
    #200000;
    mismatches++;
    close_out;
  end
endmodule : test_liu_channel_irq_enable
